// [hdl/sensor_front_end_control.sv]
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
module sensor_front_end_control (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [3:0] log_enables,
  input wire logic log_request,
  input wire logic [1:0] log_channel,
  input wire logic adc_done,
  input wire logic [9:0] adc_data,
  output logic adc_start,
  output front_end_pkg::analog_ctl_s analog_ctl,
  output logic excite_battery_on,
  output logic excite_ac_high,
  output logic excite_oe_n,
  output logic log_write,
  output logic [1:0] log_write_channel,
  output logic [9:0] log_write_data,
  output logic [1:0] limit_channel,
  output logic limit_valid
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_FINISH
  } conv_state_e;

  conv_state_e state_reg;
  conv_state_e state_next;
  front_end_pkg::settings_s cfg_reg;
  front_end_pkg::settings_s cfg_next;
  front_end_pkg::analog_ctl_s ctl_reg;
  front_end_pkg::analog_ctl_s ctl_next;
  front_end_pkg::drive_mode_e drive_reg;
  front_end_pkg::drive_mode_e drive_next;
  logic query_reg;
  logic query_next;
  logic done_reg;
  logic done_next;
  logic [9:0] result_reg;
  logic [9:0] result_next;
  logic start_reg;
  logic start_next;
  logic logw_reg;
  logic logw_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic ack_reg;
  logic ack_next;
  logic [15:0] tmo_reg;
  logic [15:0] tmo_next;
  logic bus_req;
  logic sw_start;
  logic [1:0] sw_chan;
  logic sw_query;
  logic done_clr;
  logic begin_conv;
  logic [1:0] pick_chan;
  logic pick_query;
  logic is_ext;
  front_end_pkg::drive_mode_e drive_want;

  // Bus: one wait cycle, answer on the second
  assign bus_req = (avs_read | avs_write) & ~ack_reg;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign sw_start = avs_write & ack_reg & (avs_address == front_end_pkg::OFF_CONTROL)
                    & avs_byteenable[0] & avs_writedata[front_end_pkg::CTL_START_BIT];
  assign sw_chan = avs_writedata[front_end_pkg::CTL_CHAN_LSB +: 2];
  assign sw_query = avs_writedata[front_end_pkg::CTL_QUERY_BIT];
  assign done_clr = avs_read & ack_reg & (avs_address == front_end_pkg::OFF_RESULT);

  // Software query takes priority over a log request
  always_comb begin
    pick_chan = log_channel;
    pick_query = 1'b0;
    if (sw_start) begin
      pick_chan = sw_chan;
      pick_query = sw_query;
    end
  end
  assign begin_conv = (state_reg == ST_IDLE) & (sw_start | log_request);
  assign is_ext = (pick_chan == 2'(front_end_pkg::CH_EXT_A))
                  | (pick_chan == 2'(front_end_pkg::CH_EXT_B));

  // Excitation mode decided from type, channel, supply switch and standby
  always_comb begin
    drive_want = front_end_pkg::DRIVE_HIZ;
    if (is_ext && cfg_reg.a_type == front_end_pkg::A_TYPE_AC) begin
      drive_want = front_end_pkg::DRIVE_AC;
    end else if (cfg_reg.a_type == front_end_pkg::A_TYPE_LINEAR && cfg_reg.supply_switch
                 && !cfg_reg.standby) begin
      drive_want = front_end_pkg::DRIVE_BATTERY;
    end
  end

  // Register writes and reads
  always_comb begin
    cfg_next = cfg_reg;
    rdata_next = rdata_reg;
    ack_next = bus_req;
    if (avs_write && ack_reg && avs_address == front_end_pkg::OFF_CONFIG) begin
      for (int b = 0; b < 3; b++) begin
        if (avs_byteenable[b]) begin
          for (int k = 0; k < 8; k++) begin
            if (b * 8 + k < front_end_pkg::CFG_WIDTH) begin
              cfg_next[b * 8 + k] = avs_writedata[b * 8 + k];
            end
          end
        end
      end
    end
    if (avs_read && bus_req) begin
      case (avs_address)
        front_end_pkg::OFF_CONFIG: rdata_next = {14'h0000, cfg_reg};
        front_end_pkg::OFF_STATUS: begin
          rdata_next = 32'h0000_0000;
          rdata_next[front_end_pkg::STS_BUSY_BIT] = (state_reg != ST_IDLE);
          rdata_next[front_end_pkg::STS_DONE_BIT] = done_reg;
          rdata_next[front_end_pkg::STS_CHAN_LSB +: 2] = ctl_reg.channel;
          rdata_next[front_end_pkg::STS_LOGGED_BIT] = ~query_reg;
        end
        front_end_pkg::OFF_RESULT: rdata_next = {22'h000000, result_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Conversion sequencer
  always_comb begin
    state_next = state_reg;
    ctl_next = ctl_reg;
    drive_next = drive_reg;
    query_next = query_reg;
    result_next = result_reg;
    start_next = 1'b0;
    logw_next = 1'b0;
    done_next = done_reg;
    tmo_next = tmo_reg;
    if (done_clr) begin
      done_next = 1'b0;
    end
    case (state_reg)
      ST_IDLE: begin
        if (begin_conv) begin
          // Latched only here, so held across the conversion
          ctl_next.channel = front_end_pkg::channel_e'(pick_chan);
          ctl_next.a_type = cfg_reg.a_type;
          ctl_next.b_type = cfg_reg.b_type;
          ctl_next.a_current = cfg_reg.a_current;
          ctl_next.b_gain = cfg_reg.b_gain;
          ctl_next.autorange_en = ~(is_ext & cfg_reg.use_preset);
          drive_next = drive_want;
          query_next = pick_query;
          start_next = 1'b1;
          tmo_next = 16'h0000;
          state_next = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        tmo_next = tmo_reg + 16'h0001;
        if (adc_done || tmo_reg == 16'(front_end_pkg::CONV_CYCLES)) begin
          result_next = adc_data;
          state_next = ST_FINISH;
        end
      end
      ST_FINISH: begin
        drive_next = front_end_pkg::DRIVE_HIZ;
        if (query_reg) begin
          done_next = 1'b1;
        end else begin
          logw_next = 1'b1;
        end
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cfg_reg <= front_end_pkg::settings_s'(front_end_pkg::CFG_RESET);
      ctl_reg <= '0;
      drive_reg <= front_end_pkg::DRIVE_HIZ;
      query_reg <= 1'b0;
      done_reg <= 1'b0;
      result_reg <= 10'h000;
      start_reg <= 1'b0;
      logw_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      ack_reg <= 1'b0;
      tmo_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      cfg_reg <= cfg_next;
      ctl_reg <= ctl_next;
      drive_reg <= drive_next;
      query_reg <= query_next;
      done_reg <= done_next;
      result_reg <= result_next;
      start_reg <= start_next;
      logw_reg <= logw_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      tmo_reg <= tmo_next;
    end
  end

  // Sensor order for bridges is set by the log sequencer (a, then b)
  excitation_drive u_drive (
    .clk(clk),
    .rst(rst),
    .mode(drive_reg),
    .excite_battery_on(excite_battery_on),
    .excite_ac_high(excite_ac_high),
    .excite_oe_n(excite_oe_n)
  );

  limit_select u_lim (
    .clk(clk),
    .rst(rst),
    .enables(log_enables),
    .select(cfg_reg.limit_select),
    .channel(limit_channel),
    .valid(limit_valid)
  );

  assign avs_readdata = rdata_reg;
  assign adc_start = start_reg;
  assign analog_ctl = ctl_reg;
  assign log_write = logw_reg;
  assign log_write_channel = ctl_reg.channel;
  assign log_write_data = result_reg;

endmodule

// [inc/front_end_pkg.sv]
package front_end_pkg;

  // Register byte offsets
  localparam logic [3:0] OFF_CONFIG = 4'h0;
  localparam logic [3:0] OFF_CONTROL = 4'h4;
  localparam logic [3:0] OFF_STATUS = 4'h8;
  localparam logic [3:0] OFF_RESULT = 4'hc;

  // Config register field positions
  localparam int CFG_GAIN_LSB = 0;
  localparam int CFG_CURR_LSB = 5;
  localparam int CFG_ATYPE_LSB = 10;
  localparam int CFG_BTYPE_BIT = 12;
  localparam int CFG_PRESET_BIT = 13;
  localparam int CFG_LIMSEL_LSB = 14;
  localparam int CFG_SUPPLY_BIT = 16;
  localparam int CFG_STANDBY_BIT = 17;
  localparam int CFG_WIDTH = 18;
  localparam logic [17:0] CFG_RESET = 18'h00000;

  // Control register field positions
  localparam int CTL_START_BIT = 0;
  localparam int CTL_CHAN_LSB = 1;
  localparam int CTL_QUERY_BIT = 3;

  // Status register field positions
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_DONE_BIT = 1;
  localparam int STS_CHAN_LSB = 2;
  localparam int STS_LOGGED_BIT = 4;

  // Sensor type encodings
  localparam logic [1:0] A_TYPE_LINEAR = 2'h0;
  localparam logic [1:0] A_TYPE_FOLLOWER = 2'h1;
  localparam logic [1:0] A_TYPE_RESERVED = 2'h2;
  localparam logic [1:0] A_TYPE_AC = 2'h3;
  localparam logic B_TYPE_CONDUCTIVE = 1'b0;
  localparam logic B_TYPE_FOLLOWER = 1'b1;

  // Timing: conversion time and AC excitation half period
  localparam int CLK_HZ = 25000000;
  localparam int CONV_TIME_US = 20;
  localparam int CONV_CYCLES = (CONV_TIME_US * (CLK_HZ / 1000000));
  localparam int AC_HALF_NS = 400;
  localparam int AC_HALF_CYCLES = (AC_HALF_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int ADC_WIDTH = 10;

  typedef enum logic [1:0] {
    CH_TEMP,
    CH_BATT,
    CH_EXT_A,
    CH_EXT_B
  } channel_e;

  typedef enum logic [1:0] {
    DRIVE_HIZ,
    DRIVE_BATTERY,
    DRIVE_AC
  } drive_mode_e;

  // Front-end settings
  typedef struct packed {
    logic standby;
    logic supply_switch;
    logic [1:0] limit_select;
    logic use_preset;
    logic b_type;
    logic [1:0] a_type;
    logic [4:0] a_current;
    logic [4:0] b_gain;
  } settings_s;

  // Analog control word held during a conversion
  typedef struct packed {
    channel_e channel;
    logic [4:0] a_current;
    logic [4:0] b_gain;
    logic autorange_en;
    logic [1:0] a_type;
    logic b_type;
  } analog_ctl_s;

endpackage

// [hdl/excitation_drive.sv]
module excitation_drive (
  input wire logic clk,
  input wire logic rst,
  input wire front_end_pkg::drive_mode_e mode,
  output logic excite_battery_on,
  output logic excite_ac_high,
  output logic excite_oe_n
);

  logic [7:0] div_reg;
  logic [7:0] div_next;
  logic phase_reg;
  logic phase_next;
  logic bat_reg;
  logic bat_next;
  logic oe_n_reg;
  logic oe_n_next;

  // Square wave around the reference level, swing equal to it
  always_comb begin
    div_next = div_reg;
    phase_next = phase_reg;
    bat_next = 1'b0;
    oe_n_next = 1'b1;
    if (mode == front_end_pkg::DRIVE_AC) begin
      oe_n_next = 1'b0;
      if (div_reg == 8'(front_end_pkg::AC_HALF_CYCLES - 1)) begin
        div_next = 8'h00;
        phase_next = ~phase_reg;
      end else begin
        div_next = div_reg + 8'h01;
      end
    end else begin
      div_next = 8'h00;
      phase_next = 1'b0;
      if (mode == front_end_pkg::DRIVE_BATTERY) begin
        bat_next = 1'b1;
        oe_n_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_reg <= 8'h00;
      phase_reg <= 1'b0;
      bat_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      div_reg <= div_next;
      phase_reg <= phase_next;
      bat_reg <= bat_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign excite_battery_on = bat_reg;
  assign excite_ac_high = phase_reg;
  assign excite_oe_n = oe_n_reg;

endmodule

// [hdl/limit_select.sv]
module limit_select (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] enables,
  input wire logic [1:0] select,
  output logic [1:0] channel,
  output logic valid
);

  logic [1:0] ch_next;
  logic [1:0] ch_reg;
  logic val_next;
  logic val_reg;
  logic [2:0] count;

  // Pick the n-th enabled sensor in enable order
  always_comb begin
    ch_next = 2'h0;
    val_next = 1'b0;
    count = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (enables[i]) begin
        if (!val_next && count[1:0] == select) begin
          ch_next = 2'(i);
          val_next = 1'b1;
        end
        count = count + 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ch_reg <= 2'h0;
      val_reg <= 1'b0;
    end else begin
      ch_reg <= ch_next;
      val_reg <= val_next;
    end
  end

  assign channel = ch_reg;
  assign valid = val_reg;

endmodule

// [test/adc_model.sv]
module adc_model #(
  parameter int DELAY = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic adc_start,
  input wire front_end_pkg::analog_ctl_s analog_ctl,
  output logic adc_done,
  output logic [9:0] adc_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  logic slow = 1'b0;
  initial adc_done = 1'b0;
  initial adc_data = 10'h000;
  // One channel per start, answer alternates prompt and slow, data marks the channel
  always @(posedge clk) begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data; // Not valid outside done
    if (rst) begin
      cnt <= 0;
    end else if (adc_start) begin
      cnt <= slow ? DELAY + 30 : DELAY;
      slow <= !slow;
    end else if (cnt == 1) begin
      adc_done <= 1'b1;
      adc_data <= {analog_ctl.channel, 8'h3c};
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// [test/sensor_front_end_control_monitor.sv]
module sensor_front_end_control_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_waitrequest,
  input wire logic adc_done,
  input wire logic [9:0] adc_data,
  input wire logic adc_start,
  input wire front_end_pkg::analog_ctl_s analog_ctl,
  input wire logic excite_battery_on,
  input wire logic excite_ac_high,
  input wire logic excite_oe_n,
  input wire logic log_write,
  input wire logic [9:0] log_write_data,
  input wire logic [3:0] log_enables,
  input wire logic [1:0] limit_channel,
  input wire logic limit_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Bus answer and conversion steps
  sequence s_ack; avs_waitrequest ##1 !avs_waitrequest; endsequence
  sequence s_fin; $past(adc_done, 2) && log_write_data == $past(adc_data, 2); endsequence
  property p_wait; $rose(avs_read) |-> s_ack; endproperty
  property p_single; adc_start |=> !adc_start [*2]; endproperty
  property p_hold; adc_start |=> $stable(analog_ctl) [*4]; endproperty
  property p_ac;
    adc_start && analog_ctl.a_type == front_end_pkg::A_TYPE_AC && analog_ctl.channel[1]
      |-> ##[0:2] (!excite_oe_n && !excite_battery_on);
  endproperty
  property p_batt;
    excite_battery_on |-> !excite_oe_n && analog_ctl.a_type == front_end_pkg::A_TYPE_LINEAR;
  endproperty
  // Drive is released two cycles after the finish step, one cycle after the log pulse
  property p_log; log_write |-> s_fin ##1 excite_oe_n; endproperty
  property p_limit; limit_valid && $stable(log_enables) |-> log_enables[limit_channel]; endproperty
  property p_wave; $rose(excite_ac_high) |=> (excite_ac_high || excite_oe_n) [*8]; endproperty
  a_wait: assert property (p_wait) else $error("read not answered after one wait");
  a_single: assert property (p_single) else $error("start repeated");
  a_hold: assert property (p_hold) else $error("control changed in conversion");
  a_ac: assert property (p_ac) else $error("no AC drive");
  a_batt: assert property (p_batt) else $error("battery drive wrong");
  a_log: assert property (p_log) else $error("log write wrong");
  a_limit: assert property (p_limit) else $error("limit sensor not enabled");
  a_wave: assert property (p_wave) else $error("AC half period short");
endmodule

bind sensor_front_end_control sensor_front_end_control_monitor i_sensor_front_end_control_monitor (
  .clk, .rst, .avs_read, .avs_waitrequest, .adc_done, .adc_data, .adc_start, .analog_ctl,
  .excite_battery_on, .excite_ac_high, .excite_oe_n, .log_write, .log_write_data, .log_enables,
  .limit_channel, .limit_valid
);

// [test/sensor_front_end_control_tb.sv]
module sensor_front_end_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic [3:0] log_enables = 4'h0;
  logic log_request = 1'b0;
  logic [1:0] log_channel = 2'h0;
  logic avs_waitrequest, adc_done, adc_start, excite_battery_on, excite_ac_high, excite_oe_n;
  logic log_write, limit_valid;
  logic [9:0] adc_data, log_write_data;
  logic [1:0] log_write_channel, limit_channel;
  front_end_pkg::analog_ctl_s analog_ctl;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  sensor_front_end_control i_sensor_front_end_control (.clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
    .log_enables, .log_request, .log_channel, .adc_done, .adc_data, .adc_start, .analog_ctl,
    .excite_battery_on, .excite_ac_high, .excite_oe_n, .log_write, .log_write_channel,
    .log_write_data, .limit_channel, .limit_valid);
  adc_model i_adc_model (.clk, .rst, .adc_start, .analog_ctl, .adc_done, .adc_data);
  // Verdict and end of run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] cfg(input logic [1:0] at, input logic bt, pre, sup, sb,
    input logic [1:0] lim);
    cfg = 32'(front_end_pkg::settings_s'{sb, sup, lim, pre, bt, at, 5'h0a, 5'h15});
  endfunction
  // Queried conversion, excitation sampled mid-conversion
  task automatic conv(input logic [1:0] ch, input logic [1:0] at, input logic bt, pre, sup, sb);
    logic bat;
    bat = at == 2'h0 && sup && !sb;
    bus(1'b1, front_end_pkg::OFF_CONFIG, cfg(at, bt, pre, sup, sb, 2'h0));
    bus(1'b1, front_end_pkg::OFF_CONTROL, (32'(ch) << 1) | 32'h9);
    while (adc_start !== 1'b1) @(posedge clk);
    repeat (3) @(posedge clk);
    chk(32'(analog_ctl.channel), 32'(ch), "channel");
    chk(32'(analog_ctl.a_type), 32'(at), "a type");
    chk(32'(analog_ctl.b_type), 32'(bt), "b type");
    chk(32'(analog_ctl.a_current), 32'h0a, "current");
    chk(32'(analog_ctl.b_gain), 32'h15, "gain");
    chk(32'(analog_ctl.autorange_en), 32'(!pre), "autorange");
    chk(32'(excite_battery_on), 32'(bat), "battery");
    chk(32'(excite_oe_n), 32'(!bat && !(at == 2'h3 && ch[1])), "hiz");
    do bus(1'b0, front_end_pkg::OFF_STATUS, 32'h0); while (q[1] !== 1'b1);
    chk(32'(q[4:0]), {27'h0, 1'b0, ch, 2'h2}, "status query");
    bus(1'b0, front_end_pkg::OFF_RESULT, 32'h0);
    chk(q, {22'h0, ch, 8'h3c}, "result");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      end_sim;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, front_end_pkg::OFF_CONFIG, 32'h0);
    chk(q, 32'(front_end_pkg::CFG_RESET), "cfg reset");
    bus(1'b1, front_end_pkg::OFF_CONFIG, 32'hffffffff);
    bus(1'b0, front_end_pkg::OFF_CONFIG, 32'h0);
    chk(q, 32'h3ffff, "cfg rw");
    bus(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0, "unmapped");
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      conv(i == 3 ? 2'h0 : {1'b1, i[2]}, i[0] ? 2'h3 : 2'h0, i[1], i[0] ^ i[1], i[1], i[2]);
    end
    $display("test excitation done");
    log_enables <= 4'hf;
    for (int l = 0; l < 4; l++) begin
      bus(1'b1, front_end_pkg::OFF_CONFIG, cfg(2'h1, 1'b1, 1'b1, 1'b0, 1'b0, 2'(l)));
      repeat (3) @(posedge clk);
      chk(32'(limit_channel), 32'(l), "limit");
    end
    // Sensor 1 off: no fourth enabled sensor, third one is sensor 3
    log_enables <= 4'hd;
    repeat (3) @(posedge clk);
    chk(32'(limit_valid), 32'h0, "limit none");
    bus(1'b1, front_end_pkg::OFF_CONFIG, cfg(2'h1, 1'b1, 1'b1, 1'b0, 1'b0, 2'h2));
    repeat (3) @(posedge clk);
    chk(32'(limit_channel), 32'h3, "limit skip");
    chk(32'(limit_valid), 32'h1, "limit valid");
    $display("test limit done");
    // Bridge read: input a then input b, logged
    for (int c = 2; c < 4; c++) begin
      log_channel <= 2'(c);
      log_request <= 1'b1;
      @(posedge clk);
      log_request <= 1'b0;
      while (log_write !== 1'b1) @(posedge clk);
      chk(32'(log_write_channel), 32'(c), "log channel");
      chk(32'(log_write_data), {22'h0, 2'(c), 8'h3c}, "log data");
      @(posedge clk);
    end
    bus(1'b0, front_end_pkg::OFF_STATUS, 32'h0);
    chk(32'(q[4:0]), 32'h1c, "status logged");
    $display("test logging done");
    end_sim;
  end
endmodule
